// ---- common/ccpo_pkg.sv ----
// Constants, field layout and register map of the coded-control pixel encoder.
// Assumes one core clock and AXI4-Lite access with 32-bit data.
package ccpo_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_OUT_FMT  = 8'h12;
   localparam logic [7:0] IDX_POLARITY = 8'h13;
   localparam logic [7:0] IDX_LS_DELAY = 8'h14;
   localparam logic [7:0] IDX_ACT_CNT  = 8'h15;
   localparam logic [7:0] IDX_STATUS   = 8'h16;
   localparam int         ADDR_W       = 8;

   // Output format fields
   localparam int         FMT_NARROW = 0;
   localparam int         FMT_CODED  = 1;
   localparam int         FMT_RANGE  = 2;
   localparam int         FMT_HACT   = 3;
   localparam logic [3:0] FMT_RST    = 4'h0;

   // Polarity fields; a one inverts the default level
   localparam int         POL_ACT   = 0;
   localparam int         POL_LINE  = 1;
   localparam int         POL_FIELD = 2;
   localparam int         POL_PAR   = 3;
   localparam logic [3:0] POL_RST   = 4'h0;
   localparam logic [3:0] POL_DEF   = 4'h6;

   // Horizontal timing reset values
   localparam logic [9:0] LS_DELAY_RST = 10'h080;
   localparam logic [9:0] ACT_CNT_RST  = 10'h2d0;

   // Event codes and chroma markers
   localparam logic [7:0] CODE_INVALID  = 8'h00;
   localparam logic [7:0] CODE_EOL      = 8'h01;
   localparam logic [7:0] CODE_SOL      = 8'h02;
   localparam logic [7:0] CODE_LS_ACT   = 8'h03;
   localparam logic [7:0] CODE_LS_BLANK = 8'h04;
   localparam logic [7:0] CODE_FS_EVEN  = 8'h05;
   localparam logic [7:0] CODE_FS_ODD   = 8'h06;
   localparam logic [7:0] MARK_CB       = 8'hff;
   localparam logic [7:0] MARK_CR       = 8'hfe;

   // Sample limits
   localparam logic [7:0]  C_MIN       = 8'h02;
   localparam logic [7:0]  C_MAX       = 8'hfd;
   localparam logic [7:0]  Y_CODED_MIN = 8'h10;
   localparam logic [7:0]  Y_MAX       = 8'hfd;
   localparam logic [7:0]  Y_NOM_OFS   = 8'h10;
   localparam logic [15:0] Y_SCALE     = 16'h00dc;

   // Double-rate edges from line-start code to field-start code when fld_cnt is even; with fld_cnt odd it goes out at the next slot
   localparam int LEAD_EDGES = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {BYTE_C, BYTE_Y} ccpo_byte_t;

   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction : reg_addr

endpackage : ccpo_pkg

// ---- src/ccpo_edge_sync.sv ----
// Two-flop synchroniser with rising-edge detection.
// Assumes pin_in is asynchronous to core_clk and slower than it.
`timescale 1ns/10ps
`default_nettype none
module ccpo_edge_sync (
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic pin_in,
   output logic      rise
);
   import ccpo_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic rise;
   } ccpo_sync_t;

   ccpo_sync_t s_ff;
   ccpo_sync_t nxt_s;

   always_comb begin
      nxt_s      = s_ff;
      nxt_s.s1   = pin_in;
      nxt_s.s2   = s_ff.s1;
      nxt_s.s3   = s_ff.s2;
      nxt_s.rise = s_ff.s2 & ~s_ff.s3;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign rise = s_ff.rise;

endmodule : ccpo_edge_sync
`default_nettype wire

// ---- src/ccpo_encoder.sv ----
// Coded-control pixel output encoder with AXI4-Lite registers.
// Assumes the video pipeline runs on core_clk; the link clock is a pin.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ccpo_encoder (
   input  wire logic                         core_clk,
   input  wire logic                         arst_n,
   input  wire logic [ccpo_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [ccpo_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire logic [7:0]                   vid_y,
   input  wire logic [7:0]                   vid_c,
   input  wire logic                         vid_valid,
   input  wire logic                         vid_line_start,
   input  wire logic                         vid_vactive,
   input  wire logic                         vid_field_start,
   input  wire logic                         vid_field_even,
   output logic                              vid_take,
   input  wire logic                         double_rate_clock,
   output logic [15:0]                       pixel_data_bus,
   output logic                              active_ind,
   output logic                              line_start_event,
   output logic                              field_start_event,
   output logic                              field_parity,
   output logic                              blue_diff_phase_flag
);
   import ccpo_pkg::*;

   typedef struct packed {
      logic              awrdy;
      logic              wrdy;
      logic              bvalid;
      logic              arrdy;
      logic              rvalid;
      logic              aw_have;
      logic              w_have;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic [1:0]        bresp;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic [3:0]        fmt;
      logic [3:0]        pol;
      logic [9:0]        lsd;
      logic [9:0]        apc;
      ccpo_byte_t        byte_sel;
      logic [7:0]        luma_hold;
      logic              cb;
      logic              last_cb;
      logic [10:0]       hpos;
      logic [1:0]        lead;
      logic [2:0]        fld_cnt;
      logic              ls_pend;
      logic              vact_pend;
      logic              fs_pend;
      logic              fs_even;
      logic              par_pend;
      logic              par_next;
      logic              parity;
      logic              vact;
      logic [15:0]       bus;
      logic              act_o;
      logic              ls_o;
      logic              fs_o;
      logic              par_o;
      logic              cbf_o;
      logic              take;
   } ccpo_st_t;

   localparam ccpo_st_t ST_RST = '{
      awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1,
      fmt: FMT_RST, pol: POL_RST,
      lsd: LS_DELAY_RST, apc: ACT_CNT_RST,
      byte_sel: BYTE_C, cb: 1'b1, last_cb: 1'b1,
      lead: 2'h3,
      act_o: POL_DEF[POL_ACT], ls_o: POL_DEF[POL_LINE],
      fs_o: POL_DEF[POL_FIELD], par_o: POL_DEF[POL_PAR],
      cbf_o: 1'b1,
      default: '0
   };

   function automatic logic [7:0] clamp8(input logic [7:0] v,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp8

   function automatic logic [7:0] lim_y(input logic [7:0] y,
                                        input logic       rng,
                                        input logic       cod);
      logic [15:0] sc;
      sc = {8'h00, y} * Y_SCALE;
      if (!rng) begin
         return 8'(sc[15:8] + Y_NOM_OFS);
      end
      return cod ? clamp8(y, Y_CODED_MIN, Y_MAX) : y;
   endfunction : lim_y

   function automatic logic [9:0] mrg10(input logic [9:0]  old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
      logic [9:0] r;
      r = old;
      if (be[0]) r[7:0] = d[7:0];
      if (be[1]) r[9:8] = d[9:8];
      return r;
   endfunction : mrg10

   ccpo_st_t    s_ff;
   ccpo_st_t    nxt_s;
   logic        dr_rise;
   logic [10:0] act_end;
   logic        hact;
   logic        slot;
   logic        coded;
   logic        fs_go;
   logic        ls_go;
   logic        pix;
   logic [7:0]  mark;
   logic [7:0]  c_out;
   logic [7:0]  y_out;
   logic        act_raw;

   ccpo_edge_sync u_dr_sync (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .pin_in   (double_rate_clock),
      .rise     (dr_rise)
   );

   always_comb begin
      nxt_s   = s_ff;
      act_end = {1'b0, s_ff.lsd} + {1'b0, s_ff.apc};
      hact    = (s_ff.hpos >= {1'b0, s_ff.lsd}) && (s_ff.hpos < act_end);
      slot    = dr_rise && (s_ff.byte_sel == BYTE_C);
      coded   = s_ff.fmt[FMT_CODED];
      mark    = s_ff.cb ? MARK_CB : MARK_CR;
      fs_go   = s_ff.fs_pend &&
                (s_ff.fld_cnt[0] || s_ff.lead == 2'(LEAD_EDGES - 1));
      ls_go   = s_ff.ls_pend && !fs_go;
      pix     = 1'b0;
      c_out   = clamp8(vid_c, C_MIN, C_MAX);
      y_out   = lim_y(vid_y, s_ff.fmt[FMT_RANGE], coded);
      act_raw = 1'b0;

      // Write channel capture
      if (s_axi_awvalid && s_ff.awrdy) begin
         nxt_s.aw_have = 1'b1;
         nxt_s.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_ff.wrdy) begin
         nxt_s.w_have = 1'b1;
         nxt_s.wdata  = s_axi_wdata;
         nxt_s.wstrb  = s_axi_wstrb;
      end
      if (s_ff.bvalid && s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_ff.aw_have && s_ff.w_have && !s_ff.bvalid) begin
         nxt_s.aw_have = 1'b0;
         nxt_s.w_have  = 1'b0;
         nxt_s.bvalid  = 1'b1;
         nxt_s.bresp   = RESP_OKAY;
         case (s_ff.awaddr)
            reg_addr(IDX_OUT_FMT): begin
               if (s_ff.wstrb[0]) nxt_s.fmt = s_ff.wdata[3:0];
            end
            reg_addr(IDX_POLARITY): begin
               if (s_ff.wstrb[0]) nxt_s.pol = s_ff.wdata[3:0];
            end
            reg_addr(IDX_LS_DELAY): begin
               nxt_s.lsd = mrg10(s_ff.lsd, s_ff.wdata, s_ff.wstrb);
            end
            reg_addr(IDX_ACT_CNT): begin
               nxt_s.apc = mrg10(s_ff.apc, s_ff.wdata, s_ff.wstrb);
            end
            reg_addr(IDX_STATUS): begin
               nxt_s.bresp = RESP_OKAY;
            end
            default: begin
               nxt_s.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Read channel
      if (s_ff.rvalid && s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_ff.arrdy) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp  = RESP_OKAY;
         nxt_s.rdata  = '0;
         case (s_axi_araddr)
            reg_addr(IDX_OUT_FMT):  nxt_s.rdata[3:0] = s_ff.fmt;
            reg_addr(IDX_POLARITY): nxt_s.rdata[3:0] = s_ff.pol;
            reg_addr(IDX_LS_DELAY): nxt_s.rdata[9:0] = s_ff.lsd;
            reg_addr(IDX_ACT_CNT):  nxt_s.rdata[9:0] = s_ff.apc;
            reg_addr(IDX_STATUS): begin
               nxt_s.rdata[7:0] = {s_ff.par_pend, s_ff.fld_cnt,
                                   s_ff.parity, s_ff.cb,
                                   s_ff.fs_pend, s_ff.ls_pend};
            end
            default: begin
               nxt_s.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Link edge counter since the last line-start slot
      nxt_s.take = 1'b0;
      if (dr_rise && s_ff.lead != 2'h3) begin
         nxt_s.lead = 2'(s_ff.lead + 2'h1);
      end

      // One pixel slot is two double-rate edges, chroma then luma
      if (dr_rise) begin
         nxt_s.byte_sel = (s_ff.byte_sel == BYTE_C) ? BYTE_Y : BYTE_C;
         if (s_ff.byte_sel == BYTE_Y && s_ff.fmt[FMT_NARROW]) begin
            nxt_s.bus = {s_ff.luma_hold, 8'h00};
         end
      end

      if (slot) begin
         if (coded && fs_go) begin
            c_out = mark;
            y_out = s_ff.fs_even ? CODE_FS_EVEN : CODE_FS_ODD;
         end else if (coded && ls_go) begin
            c_out = mark;
            y_out = s_ff.vact_pend ? CODE_LS_ACT : CODE_LS_BLANK;
         end else if (coded && 11'(s_ff.hpos + 11'h001) == {1'b0, s_ff.lsd}) begin
            c_out = mark;
            y_out = CODE_SOL;
         end else if (coded && s_ff.hpos == act_end) begin
            c_out = mark;
            y_out = CODE_EOL;
         end else if (coded && !vid_valid) begin
            c_out = s_ff.last_cb ? MARK_CB : MARK_CR;
            y_out = CODE_INVALID;
         end else begin
            pix = 1'b1;
         end

         if (pix) begin
            nxt_s.last_cb = s_ff.cb;
            nxt_s.take    = 1'b1;
         end

         if (s_ff.fmt[FMT_NARROW]) begin
            nxt_s.bus       = {c_out, 8'h00};
            nxt_s.luma_hold = y_out;
         end else begin
            nxt_s.bus       = {y_out, c_out};
            nxt_s.luma_hold = y_out;
         end

         // Phase and horizontal position
         if (ls_go) begin
            nxt_s.cb   = 1'b1;
            nxt_s.hpos = '0;
            nxt_s.lead = '0;
            nxt_s.vact = s_ff.vact_pend;
         end else begin
            nxt_s.cb = ~s_ff.cb;
            if (s_ff.hpos != 11'h7ff) begin
               nxt_s.hpos = 11'(s_ff.hpos + 11'h001);
            end
         end

         // Parity changes when horizontal active ends
         if (s_ff.hpos == act_end && s_ff.par_pend) begin
            nxt_s.parity   = s_ff.par_next;
            nxt_s.par_pend = 1'b0;
         end

         // New field start wins over the parity clear
         if (fs_go) begin
            nxt_s.fld_cnt  = 3'(s_ff.fld_cnt + 3'h1);
            nxt_s.par_pend = 1'b1;
            nxt_s.par_next = ~s_ff.fs_even;
         end

         act_raw = s_ff.fmt[FMT_HACT] ? hact : (hact && s_ff.vact);
         nxt_s.act_o = act_raw ^ POL_DEF[POL_ACT] ^ s_ff.pol[POL_ACT];
         nxt_s.ls_o  = ls_go ^ POL_DEF[POL_LINE] ^ s_ff.pol[POL_LINE];
         nxt_s.fs_o  = fs_go ^ POL_DEF[POL_FIELD] ^ s_ff.pol[POL_FIELD];
         nxt_s.cbf_o = s_ff.cb;
      end
      nxt_s.par_o = nxt_s.parity ^ POL_DEF[POL_PAR] ^ s_ff.pol[POL_PAR];

      // Pending events; a new arrival wins over the clear
      if (slot && ls_go) nxt_s.ls_pend = 1'b0;
      if (slot && fs_go) nxt_s.fs_pend = 1'b0;
      if (vid_line_start) begin
         nxt_s.ls_pend   = 1'b1;
         nxt_s.vact_pend = vid_vactive;
      end
      if (vid_field_start) begin
         nxt_s.fs_pend = 1'b1;
         nxt_s.fs_even = vid_field_even;
      end

      nxt_s.awrdy = !nxt_s.aw_have && !nxt_s.bvalid;
      nxt_s.wrdy  = !nxt_s.w_have && !nxt_s.bvalid;
      nxt_s.arrdy = !nxt_s.rvalid;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= ST_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign s_axi_awready        = s_ff.awrdy;
   assign s_axi_wready         = s_ff.wrdy;
   assign s_axi_bvalid         = s_ff.bvalid;
   assign s_axi_bresp          = s_ff.bresp;
   assign s_axi_arready        = s_ff.arrdy;
   assign s_axi_rvalid         = s_ff.rvalid;
   assign s_axi_rdata          = s_ff.rdata;
   assign s_axi_rresp          = s_ff.rresp;
   assign vid_take             = s_ff.take;
   assign pixel_data_bus       = s_ff.bus;
   assign active_ind           = s_ff.act_o;
   assign line_start_event     = s_ff.ls_o;
   assign field_start_event    = s_ff.fs_o;
   assign field_parity         = s_ff.par_o;
   assign blue_diff_phase_flag = s_ff.cbf_o;

endmodule : ccpo_encoder
`default_nettype wire

// ---- tb/ccpo_encoder_props.sv ----
// Port checker for the coded-control pixel encoder.
// Assumes a bind onto ccpo_encoder; it sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module ccpo_encoder_props (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        vid_take,
   input wire logic        double_rate_clock,
   input wire logic [15:0] pixel_data_bus
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   a_bus_link_edge:
      assert property ($changed(pixel_data_bus) |->
         $past(double_rate_clock, 2)) else $error("bus moved off a link edge");
   a_chroma_floor:
      assert property (pixel_data_bus[7:0] != 8'h01)
      else $error("chroma byte below floor");
   a_take_spacing:
      assert property (vid_take |=> !vid_take [*8])
      else $error("sample taken twice within a slot");
   a_bresp_time:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
         s_axi_wready |-> ##[2:3] s_axi_bvalid) else $error("late bvalid");
   a_bvalid_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_aw_refuse:
      assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address open during response");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=>
         s_axi_rvalid && !s_axi_arready) else $error("read not answered");
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
endmodule : ccpo_encoder_props
bind ccpo_encoder ccpo_encoder_props i_ccpo_encoder_props (.core_clk,
   .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .vid_take,
   .double_rate_clock, .pixel_data_bus);
`default_nettype wire

// ---- tb/ccpo_link_rx.sv ----
// Receiver model of the narrow pixel bus; it also makes the link clock.
// Assumes the encoder launches one byte per link rising edge.
`timescale 1ns/10ps
`default_nettype none
module ccpo_link_rx (
   input  wire logic        arst_n,
   input  wire logic        run,
   input  wire logic [15:0] pixel_data_bus,
   input  wire logic        blue_diff_phase_flag,
   output logic             double_rate_clock,
   output logic [7:0]       slot_c,
   output logic [7:0]       slot_y,
   output logic             slot_cb,
   output int               slot_cnt
);
   logic [7:0] c_hold;
   logic       cb_hold;
   int         n = -1;
   // Link clock idles low while not running
   initial begin
      double_rate_clock = 1'b0;
      #137;
      forever #400 double_rate_clock = run & ~double_rate_clock;
   end
   // Each edge takes the byte launched at the edge before; chroma first
   always @(posedge double_rate_clock or negedge arst_n) begin
      if (!arst_n) begin
         n = -1;
         slot_cnt = 0;
      end else begin
         if (n >= 0 && n[0] == 1'b0) begin
            c_hold  = pixel_data_bus[15:8];
            cb_hold = blue_diff_phase_flag;
         end else if (n >= 0) begin
            // Marker pairs accepted on either phase
            slot_c  = c_hold;
            slot_cb = cb_hold;
            slot_y  = pixel_data_bus[15:8];
            slot_cnt++;
         end
         n++;
      end
   end
endmodule : ccpo_link_rx
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the coded-control pixel encoder.
// Assumes the receiver model makes the link clock and splits slots.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module tb;
   import ccpo_pkg::*;
   localparam int LSD = 6;
   localparam int APC = 8;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, vid_y, vid_c, slot_c, slot_y;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, vid_valid, vid_line_start;
   logic        vid_vactive, vid_field_start, vid_field_even, vid_take;
   logic        double_rate_clock, active_ind, line_start_event, slot_cb;
   logic        field_start_event, field_parity, blue_diff_phase_flag;
   logic        run, rng, mon_on, lcb;
   logic [15:0] pixel_data_bus, q[$];
   logic [7:0]  seen;
   int          fail_count, tests_run, slot_cnt, pos, cyc;
   ccpo_encoder i_ccpo_encoder (.core_clk, .arst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vid_y,
      .vid_c, .vid_valid, .vid_line_start, .vid_vactive, .vid_field_start,
      .vid_field_even, .vid_take, .double_rate_clock, .pixel_data_bus,
      .active_ind, .line_start_event, .field_start_event, .field_parity,
      .blue_diff_phase_flag);
   ccpo_link_rx i_ccpo_link_rx (.arst_n, .run, .pixel_data_bus,
      .blue_diff_phase_flag, .double_rate_clock, .slot_c, .slot_y, .slot_cb,
      .slot_cnt);
   always #50 core_clk = ~core_clk;
   function automatic logic [7:0] pick();
      case ($urandom_range(4))
         0: return 8'h00;
         1: return 8'hff;
         2: return 8'h80;
         default: return 8'($urandom);
      endcase
   endfunction : pick
   function automatic logic [7:0] exp_y(input logic [7:0] y);
      if (!rng) return 8'(16 + int'(y) * 220 / 256);
      if (y < 8'h10) return 8'h10;
      return (y > 8'hfd) ? 8'hfd : y;
   endfunction : exp_y
   function automatic logic [7:0] exp_c(input logic [7:0] c);
      return (c < 8'h02) ? 8'h02 : (c > 8'hfd) ? 8'hfd : c;
   endfunction : exp_c
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && s_axi_awready !== 1'b1) ||
                 (s_axi_wvalid && s_axi_wready !== 1'b1));
      repeat ($urandom_range(2)) @(posedge core_clk);
      s_axi_bready <= 1'b1;
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      repeat ($urandom_range(2)) @(posedge core_clk);
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic slots(input int k);
      int s0;
      s0 = slot_cnt;
      wait (slot_cnt >= s0 + k);
      @(posedge core_clk);
   endtask : slots
   task automatic cfg(input logic [3:0] f);
      logic [31:0] d;
      logic [1:0]  r;
      mon_on    <= 1'b0;
      vid_valid <= 1'b0;
      wr(8'h48, {28'h0, f}, r);
      rd(8'h48, d, r);
      `CHK(d[3:0], f)
      slots(2);
      q.delete();
      rng = f[FMT_RANGE];
      pos = -1000;
      mon_on    <= 1'b1;
   endtask : cfg
   // Fresh sample offered after each take
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
      if (vid_take === 1'b1) begin
         q.push_back({vid_y, vid_c});
         vid_y <= pick();
         vid_c <= pick();
      end
   end
   // Slot checker
   always @(slot_cnt) begin
      logic [15:0] e;
      logic        ph;
      if (mon_on) begin
         pos++;
         if (slot_c === MARK_CB || slot_c === MARK_CR) begin
            ph = (slot_y === CODE_INVALID) ? lcb : slot_cb;
            `CHK(slot_c, ph ? MARK_CB : MARK_CR)
            `CHK(slot_y < 8'h07, 1'b1)
            seen[slot_y[2:0]] = 1'b1;
            if (slot_y == CODE_LS_ACT || slot_y == CODE_LS_BLANK) pos = -1;
            if (slot_y == CODE_SOL) `CHK(pos, LSD - 1)
            if (slot_y == CODE_EOL) `CHK(pos, LSD + APC)
         end else if (q.size() > 0) begin
            e = q.pop_front();
            `CHK(slot_y, exp_y(e[15:8]))
            `CHK(slot_c, exp_c(e[7:0]))
         end
         if (pos == 0) `CHK(slot_cb, 1'b1)
      end
      if (slot_c !== MARK_CB && slot_c !== MARK_CR) lcb = slot_cb;
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [9:0]  rst_v [4];
      rst_v = '{10'(FMT_RST), 10'(POL_RST), LS_DELAY_RST, ACT_CNT_RST};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, run, mon_on, vid_valid, rng, seen, lcb} = '0;
      {vid_line_start, vid_vactive, vid_field_start, vid_field_even} = '0;
      {s_axi_awaddr, s_axi_araddr, vid_y, vid_c, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h3;
      void'($urandom(32'he276));
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      `CHK({line_start_event, field_start_event}, 2'b11)
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * (18 + i)), d, r);
         `CHK(d[9:0], rst_v[i])
      end
      rd(8'h58, d, r);
      `CHK(d[7:0], 8'h04)
      rd(8'h7c, d, r);
      `CHK(r, RESP_SLVERR)
      wr(8'h7c, 32'h0, r);
      `CHK(r, RESP_SLVERR)
      run <= 1'b1;
      wr(8'h4c, 32'hf, r);
      slots(2);
      `CHK({line_start_event, field_start_event}, 2'b00)
      $display("test registers done");
      cfg(4'h1);
      slots(30);
      $display("test uncoded range done");
      wr(8'h50, LSD, r);
      wr(8'h54, APC, r);
      cfg(4'h7);
      for (int i = 0; i < 6; i++) begin
         seen = '0;
         vid_line_start  <= 1'b1;
         vid_vactive     <= 1'($urandom_range(1));
         vid_field_start <= 1'(i % 2 == 0);
         vid_field_even  <= 1'($urandom_range(1));
         vid_valid       <= 1'(i != 3);
         @(posedge core_clk);
         vid_line_start  <= 1'b0;
         vid_field_start <= 1'b0;
         slots(LSD + APC + 4);
         `CHK(seen[vid_vactive ? 3 : 4], 1'b1)
         if (i % 2 == 0) `CHK(seen[vid_field_even ? 5 : 6], 1'b1)
         `CHK(seen[2:1], 2'b11)
         `CHK(seen[0], 1'(i == 3))
         `CHK(active_ind, 1'b1)
         if (i % 2 == 0) `CHK(field_parity, vid_field_even)
      end
      $display("test coded lines done");
      summarize();
   end
endmodule : tb
`default_nettype wire
